// file: core/pcl_limit_check.sv
// one idle-state gate: scales a limit and compares the exit latency
module pcl_limit_check
   import pcl_pkg::*;
(
   input wire logic [pcl_pkg::PCL_CFG_W-1:0] i_cfg,
   input wire logic [pcl_pkg::PCL_NS_W-1:0] i_exit_lat_ns,
   output logic o_allowed,
   output logic [pcl_pkg::PCL_NS_W-1:0] o_budget_ns
);
   logic [5:0] shift_w;
   logic unit_ok_w;

   // unit decode and scaling
   assign shift_w = pcl_unit_shift(i_cfg[PCL_UNIT_LSB +: PCL_UNIT_W]);
   assign unit_ok_w = ~shift_w[5];
   assign o_budget_ns = pcl_budget_ns(i_cfg);

   // entry only with a valid, well-formed limit covering the latency
   assign o_allowed = i_cfg[PCL_VALID_BIT] && unit_ok_w
                      && (i_exit_lat_ns <= o_budget_ns);
endmodule

// file: core/pcl_pkg.sv
// package idle interrupt response limit: shared constants and helpers
package pcl_pkg;
   // register addresses in the model-specific register space
   localparam logic [31:0] PCL_ADDR_SHALLOW = 32'h0000_060A;
   localparam logic [31:0] PCL_ADDR_DEEP = 32'h0000_060B;
   // widths
   localparam int PCL_ADDR_W = 32;
   localparam int PCL_DATA_W = 64;
   localparam int PCL_CFG_W = 16;
   localparam int PCL_LIM_W = 10;
   localparam int PCL_UNIT_W = 3;
   localparam int PCL_NS_W = 36;
   // field positions
   localparam int PCL_LIM_LSB = 0;
   localparam int PCL_UNIT_LSB = 10;
   localparam int PCL_VALID_BIT = 15;
   // writable bits: valid, unit and limit; 14:13 and 63:16 reserved
   localparam logic [PCL_CFG_W-1:0] PCL_STORE_MASK = 16'h9FFF;
   localparam logic [PCL_CFG_W-1:0] PCL_CFG_RST = 16'h0000;
   // unit encodings, each a power of two nanoseconds
   localparam logic [PCL_UNIT_W-1:0] PCL_UNIT_1NS = 3'h0;
   localparam logic [PCL_UNIT_W-1:0] PCL_UNIT_32NS = 3'h1;
   localparam logic [PCL_UNIT_W-1:0] PCL_UNIT_1024NS = 3'h2;
   localparam logic [PCL_UNIT_W-1:0] PCL_UNIT_32768NS = 3'h3;
   localparam logic [PCL_UNIT_W-1:0] PCL_UNIT_1048576NS = 3'h4;
   localparam logic [PCL_UNIT_W-1:0] PCL_UNIT_33554432NS = 3'h5;

   // unit encoding to shift count; bit 5 flags an undefined encoding
   function automatic logic [5:0] pcl_unit_shift(input logic [PCL_UNIT_W-1:0] unit);
      logic [5:0] s;
      s = 6'h20;
      unique case (unit)
         PCL_UNIT_1NS: s = 6'h00;
         PCL_UNIT_32NS: s = 6'h05;
         PCL_UNIT_1024NS: s = 6'h0A;
         PCL_UNIT_32768NS: s = 6'h0F;
         PCL_UNIT_1048576NS: s = 6'h14;
         PCL_UNIT_33554432NS: s = 6'h19;
         default: s = 6'h20;
      endcase
      return s;
   endfunction

   // limit scaled by unit, in nanoseconds
   function automatic logic [PCL_NS_W-1:0] pcl_budget_ns(input logic [PCL_CFG_W-1:0] cfg);
      logic [5:0] s;
      logic [PCL_NS_W-1:0] lim;
      s = pcl_unit_shift(cfg[PCL_UNIT_LSB +: PCL_UNIT_W]);
      lim = {{(PCL_NS_W-PCL_LIM_W){1'b0}}, cfg[PCL_LIM_LSB +: PCL_LIM_W]};
      return lim << s[4:0];
   endfunction
endpackage

// file: core/pcl_top.sv
// package idle interrupt response limit registers and entry gates
module pcl_top
(
   input wire logic i_clk_sys,
   input wire logic i_sys_rst,
   input wire logic i_cfg_wr,
   input wire logic i_cfg_rd,
   input wire logic [pcl_pkg::PCL_ADDR_W-1:0] i_cfg_addr,
   input wire logic [pcl_pkg::PCL_DATA_W-1:0] i_cfg_wdata,
   output logic [pcl_pkg::PCL_DATA_W-1:0] o_cfg_rdata,
   output logic o_cfg_ack,
   output logic o_cfg_err,
   input wire logic [pcl_pkg::PCL_NS_W-1:0] i_shallow_exit_lat_ns,
   input wire logic [pcl_pkg::PCL_NS_W-1:0] i_deep_exit_lat_ns,
   output logic o_shallow_allowed,
   output logic o_deep_allowed,
   output logic [pcl_pkg::PCL_NS_W-1:0] o_shallow_budget_ns,
   output logic [pcl_pkg::PCL_NS_W-1:0] o_deep_budget_ns
);
   import pcl_pkg::*;

   logic [PCL_CFG_W-1:0] shallow_idle_irq_response_limit_r;
   logic [PCL_CFG_W-1:0] deep_idle_irq_response_limit_r;
   logic hit_shallow_w;
   logic hit_deep_w;
   logic [PCL_CFG_W-1:0] wr_val_w;
   logic [PCL_DATA_W-1:0] rd_nxt;
   logic shallow_ok_w;
   logic deep_ok_w;
   logic [PCL_NS_W-1:0] shallow_budget_w;
   logic [PCL_NS_W-1:0] deep_budget_w;

   // address decode and write value with reserved bits dropped
   assign hit_shallow_w = (i_cfg_addr == PCL_ADDR_SHALLOW);
   assign hit_deep_w = (i_cfg_addr == PCL_ADDR_DEEP);
   assign wr_val_w = i_cfg_wdata[PCL_CFG_W-1:0] & PCL_STORE_MASK;

   // shallow register storage
   always_ff @(posedge i_clk_sys or posedge i_sys_rst)
   begin
      if (i_sys_rst)
         shallow_idle_irq_response_limit_r <= PCL_CFG_RST;
      else if (i_cfg_wr && hit_shallow_w)
         shallow_idle_irq_response_limit_r <= wr_val_w;
   end

   // deep register storage
   always_ff @(posedge i_clk_sys or posedge i_sys_rst)
   begin
      if (i_sys_rst)
         deep_idle_irq_response_limit_r <= PCL_CFG_RST;
      else if (i_cfg_wr && hit_deep_w)
         deep_idle_irq_response_limit_r <= wr_val_w;
   end

   // read mux; reserved bits read zero, read sees value before a same-cycle write
   always_comb
   begin
      rd_nxt = '0;
      if (hit_shallow_w)
         rd_nxt[PCL_CFG_W-1:0] = shallow_idle_irq_response_limit_r;
      else if (hit_deep_w)
         rd_nxt[PCL_CFG_W-1:0] = deep_idle_irq_response_limit_r;
   end

   // read data and acknowledge, one cycle after the request
   always_ff @(posedge i_clk_sys or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         o_cfg_rdata <= '0;
         o_cfg_ack <= 1'b0;
      end
      else
      begin
         o_cfg_ack <= i_cfg_rd || i_cfg_wr;
         if (i_cfg_rd)
            o_cfg_rdata <= rd_nxt;
      end
   end

   // unmapped access flag, pulses with the acknowledge
   always_ff @(posedge i_clk_sys or posedge i_sys_rst)
   begin
      if (i_sys_rst)
         o_cfg_err <= 1'b0;
      else
         o_cfg_err <= (i_cfg_rd || i_cfg_wr) && !hit_shallow_w && !hit_deep_w;
   end

   // shallow idle gate
   pcl_limit_check u_shallow_chk
   (
      .i_cfg(shallow_idle_irq_response_limit_r),
      .i_exit_lat_ns(i_shallow_exit_lat_ns),
      .o_allowed(shallow_ok_w),
      .o_budget_ns(shallow_budget_w)
   );

   // deep idle gate; package latency only, core exit time excluded
   pcl_limit_check u_deep_chk
   (
      .i_cfg(deep_idle_irq_response_limit_r),
      .i_exit_lat_ns(i_deep_exit_lat_ns),
      .o_allowed(deep_ok_w),
      .o_budget_ns(deep_budget_w)
   );

   // registered gate outputs
   always_ff @(posedge i_clk_sys or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         o_shallow_allowed <= 1'b0;
         o_deep_allowed <= 1'b0;
      end
      else
      begin
         o_shallow_allowed <= shallow_ok_w;
         o_deep_allowed <= deep_ok_w;
      end
   end

   // registered budgets, zero while the register is not valid
   always_ff @(posedge i_clk_sys or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         o_shallow_budget_ns <= '0;
         o_deep_budget_ns <= '0;
      end
      else
      begin
         o_shallow_budget_ns <= shallow_idle_irq_response_limit_r[PCL_VALID_BIT]
                                ? shallow_budget_w : '0;
         o_deep_budget_ns <= deep_idle_irq_response_limit_r[PCL_VALID_BIT]
                             ? deep_budget_w : '0;
      end
   end

   // checks
   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (i_sys_rst);

   sequence s_wr_deep;
      i_cfg_wr && hit_deep_w && !i_cfg_rd;
   endsequence

   sequence s_rd_deep;
      i_cfg_rd && hit_deep_w && !i_cfg_wr;
   endsequence

   // a write to deep shows on a later read with reserved bits cleared
   a_deep_write_readback: assert property (
      s_wr_deep ##1 s_rd_deep |=>
      o_cfg_ack && o_cfg_rdata == {48'h0, $past(i_cfg_wdata[15:0], 2) & 16'h9FFF})
      else $error("deep register readback mismatch");

   a_shallow_write_held: assert property (
      i_cfg_wr && hit_shallow_w |=>
      shallow_idle_irq_response_limit_r[12:10] == $past(i_cfg_wdata[12:10])
      && shallow_idle_irq_response_limit_r[14:13] == 2'h0)
      else $error("shallow unit field not stored");

   a_unmapped_error: assert property (
      i_cfg_rd && !hit_shallow_w && !hit_deep_w |=>
      o_cfg_err && o_cfg_ack && o_cfg_rdata == 64'h0)
      else $error("unmapped read not flagged");

   a_invalid_blocks_entry: assert property (
      !deep_idle_irq_response_limit_r[15] |=> !o_deep_allowed && o_deep_budget_ns == '0)
      else $error("deep entry allowed while not valid");

   a_bad_unit_blocks: assert property (
      shallow_idle_irq_response_limit_r[12:11] == 2'h3 |=> !o_shallow_allowed)
      else $error("undefined unit allowed entry");

   a_unit_32_scale: assert property (
      deep_idle_irq_response_limit_r[15] && deep_idle_irq_response_limit_r[12:10] == 3'h1
      |=> o_deep_budget_ns == {21'h0, $past(deep_idle_irq_response_limit_r[9:0]), 5'h0})
      else $error("deep budget not scaled by 32");

   a_deep_latency_over: assert property (
      i_deep_exit_lat_ns > {26'h0, deep_idle_irq_response_limit_r[9:0]}
      && deep_idle_irq_response_limit_r[12:10] == 3'h0 |=> !o_deep_allowed)
      else $error("deep entry allowed beyond 1 ns budget");

   a_shallow_within_budget: assert property (
      shallow_idle_irq_response_limit_r[15] && shallow_idle_irq_response_limit_r[12:10] == 3'h5
      && i_shallow_exit_lat_ns <= {1'b0, shallow_idle_irq_response_limit_r[9:0], 25'h0}
      |=> o_shallow_allowed)
      else $error("shallow entry refused within budget");

   a_ack_one_cycle: assert property (
      s_rd_deep ##1 !i_cfg_rd && !i_cfg_wr |=> !o_cfg_ack)
      else $error("acknowledge longer than one cycle");
endmodule

// file: tb/pcl_top_bench.sv
// self-checking bench for the idle response limit registers and gates
module pcl_top_bench;
   timeunit 1ns;
   timeprecision 1ns;
   import pcl_pkg::*;
   logic clk_sys = 1'b0;
   logic sys_rst = 1'b1;
   logic cfg_wr = 1'b0;
   logic cfg_rd = 1'b0;
   logic [31:0] cfg_addr = 32'h0000_0000;
   logic [63:0] cfg_wdata = 64'h0;
   logic [63:0] cfg_rdata;
   logic cfg_ack;
   logic cfg_err;
   logic [35:0] sh_lat = 36'h0;
   logic [35:0] dp_lat = 36'h0;
   logic sh_ok;
   logic dp_ok;
   logic [35:0] sh_budget;
   logic [35:0] dp_budget;
   int mismatches = 0;
   int tests_run = 0;
   // 100 ns system clock
   always #50 clk_sys = ~clk_sys;
   pcl_top i_pcl_top (.i_clk_sys(clk_sys), .i_sys_rst(sys_rst), .i_cfg_wr(cfg_wr),
      .i_cfg_rd(cfg_rd), .i_cfg_addr(cfg_addr), .i_cfg_wdata(cfg_wdata),
      .o_cfg_rdata(cfg_rdata), .o_cfg_ack(cfg_ack), .o_cfg_err(cfg_err),
      .i_shallow_exit_lat_ns(sh_lat), .i_deep_exit_lat_ns(dp_lat),
      .o_shallow_allowed(sh_ok), .o_deep_allowed(dp_ok),
      .o_shallow_budget_ns(sh_budget), .o_deep_budget_ns(dp_budget));
   task automatic stop_test();
      $display("checks %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic check_bit(input string what, input logic exp, input logic got);
      tests_run++;
      if (got !== exp)
      begin
         mismatches++;
         $display("unexpected %s expected %0b seen %0b", what, exp, got);
      end
   endtask
   task automatic check_word(input string what, input logic [63:0] exp, input logic [63:0] got);
      tests_run++;
      if (got !== exp)
      begin
         mismatches++;
         $display("unexpected %s expected %0h seen %0h", what, exp, got);
      end
   endtask
   // one access, driven at the falling edge, answer judged one cycle later
   task automatic access(input logic wr, input logic [31:0] addr, input logic [63:0] wd,
      input logic exp_err);
      @(negedge clk_sys);
      cfg_wr = wr;
      cfg_rd = !wr;
      cfg_addr = addr;
      cfg_wdata = wd;
      @(negedge clk_sys);
      cfg_wr = 1'b0;
      cfg_rd = 1'b0;
      check_bit("ack", 1'b1, cfg_ack);
      check_bit("err", exp_err, cfg_err);
   endtask
   // write, set both latencies, let the gates follow one edge later
   task automatic gate(input logic [31:0] addr, input logic [15:0] cfg, input logic [35:0] lat);
      access(1'b1, addr, {48'h0, cfg}, 1'b0);
      sh_lat = lat;
      dp_lat = lat;
      @(negedge clk_sys);
   endtask
   task automatic test_reset();
      check_word("deep budget", 64'h0, {28'h0, dp_budget});
      check_bit("deep allowed", 1'b0, dp_ok);
      check_bit("shallow allowed", 1'b0, sh_ok);
      $display("test reset done");
   endtask
   task automatic test_units();
      int sh[6] = '{0, 5, 10, 15, 20, 25};
      logic [35:0] exp;
      for (int u = 0; u < 8; u++)
      begin
         exp = (u < 6) ? (36'h3FF << sh[u]) : 36'h0;
         gate(PCL_ADDR_DEEP, {1'b1, 2'b00, 3'(u), 10'h3FF}, exp);
         check_bit("deep allowed at limit", u < 6, dp_ok);
         if (u < 6)
         begin
            check_word("deep budget", {28'h0, exp}, {28'h0, dp_budget});
            gate(PCL_ADDR_DEEP, {1'b1, 2'b00, 3'(u), 10'h3FF}, exp + 36'h1);
            check_bit("deep allowed over limit", 1'b0, dp_ok);
         end
      end
      $display("test units done");
   endtask
   task automatic test_valid();
      gate(PCL_ADDR_DEEP, 16'h0401, 36'h0);
      check_word("deep budget", 64'h0, {28'h0, dp_budget});
      check_bit("deep allowed", 1'b0, dp_ok);
      gate(PCL_ADDR_SHALLOW, 16'h8801, 36'd1024);
      check_word("shallow budget", 64'd1024, {28'h0, sh_budget});
      check_bit("shallow allowed", 1'b1, sh_ok);
      check_bit("deep still blocked", 1'b0, dp_ok);
      gate(PCL_ADDR_SHALLOW, 16'h9401, 36'h200_0000);
      check_word("shallow top unit budget", 64'h200_0000, {28'h0, sh_budget});
      check_bit("shallow allowed top unit", 1'b1, sh_ok);
      $display("test valid done");
   endtask
   task automatic test_reserved();
      access(1'b1, PCL_ADDR_SHALLOW, 64'hFFFF_FFFF_FFFF_FFFF, 1'b0);
      access(1'b0, PCL_ADDR_SHALLOW, 64'h0, 1'b0);
      check_word("shallow readback", 64'h9FFF, cfg_rdata);
      access(1'b1, 32'h0000_0600, 64'h8401, 1'b1);
      access(1'b0, 32'h0000_0600, 64'h0, 1'b1);
      check_word("unmapped readback", 64'h0, cfg_rdata);
      access(1'b0, PCL_ADDR_DEEP, 64'h0, 1'b0);
      check_word("deep readback", 64'h0401, cfg_rdata);
      $display("test reserved done");
   endtask
   // write then read on consecutive edges, then read and write in one cycle
   task automatic test_back_to_back();
      @(negedge clk_sys);
      cfg_wr = 1'b1;
      cfg_addr = PCL_ADDR_DEEP;
      cfg_wdata = 64'hFFFF_0000_0000_E405;
      @(negedge clk_sys);
      cfg_wr = 1'b0;
      cfg_rd = 1'b1;
      check_bit("write ack", 1'b1, cfg_ack);
      @(negedge clk_sys);
      cfg_rd = 1'b0;
      check_bit("read ack", 1'b1, cfg_ack);
      check_word("deep back to back readback", 64'h8405, cfg_rdata);
      check_word("deep budget unit 32", 64'h0A0, {28'h0, dp_budget});
      check_bit("deep allowed over budget", 1'b0, dp_ok);
      @(negedge clk_sys);
      check_bit("ack released", 1'b0, cfg_ack);
      cfg_wr = 1'b1;
      cfg_rd = 1'b1;
      cfg_wdata = 64'h8000;
      @(negedge clk_sys);
      cfg_wr = 1'b0;
      cfg_rd = 1'b0;
      check_bit("ack read and write", 1'b1, cfg_ack);
      check_word("read before write", 64'h8405, cfg_rdata);
      access(1'b0, PCL_ADDR_DEEP, 64'h0, 1'b0);
      check_word("deep after joint write", 64'h8000, cfg_rdata);
      @(negedge clk_sys);
      $display("test back to back done");
   endtask
   // watchdog cuts a hang short
   initial
   begin
      #2000000;
      mismatches++;
      stop_test();
   end
   initial
   begin
      repeat (5) @(negedge clk_sys);
      sys_rst = 1'b0;
      @(negedge clk_sys);
      test_reset();
      test_units();
      test_valid();
      test_reserved();
      test_back_to_back();
      stop_test();
   end
endmodule
